// file: common/cursor_window_consts.svh
// Purpose: offsets, field widths, reset values and sprite size for the cursor/window registers
// Assumes: register index n sits at APB byte address 4*n
// Notes: definitions only
`ifndef CURSOR_WINDOW_CONSTS_SVH
`define CURSOR_WINDOW_CONSTS_SVH

`define CW_IDX_CURSOR_X_LOW 6'h00
`define CW_IDX_CURSOR_X_HIGH 6'h01
`define CW_IDX_CURSOR_Y_LOW 6'h02
`define CW_IDX_CURSOR_Y_HIGH 6'h03
`define CW_IDX_SPRITE_ORIGIN_X 6'h04
`define CW_IDX_SPRITE_ORIGIN_Y 6'h05
`define CW_IDX_WIN_BEGIN_X_LOW 6'h10
`define CW_IDX_WIN_BEGIN_X_HIGH 6'h11
`define CW_IDX_WIN_END_X_LOW 6'h12
`define CW_IDX_WIN_END_X_HIGH 6'h13
`define CW_IDX_WIN_BEGIN_Y_LOW 6'h14
`define CW_IDX_WIN_BEGIN_Y_HIGH 6'h15
`define CW_IDX_WIN_END_Y_LOW 6'h16
`define CW_IDX_WIN_END_Y_HIGH 6'h17
`define CW_IDX_MAX 6'h17

`define CW_HIGH_BITS 4
`define CW_SPRITE_BITS 6
`define CW_CURSOR_RESET 8'h00
`define CW_SPRITE_RESET 6'h1f
`define CW_WIN_RESET 8'h00
`define CW_SPRITE_SIZE 7'h40

`endif

// file: common/cursor_window_pkg.sv
// Purpose: shared types for the cursor/window register bank
// Assumes: 12-bit screen coordinates
// Notes: constants live in cursor_window_consts.svh
package cursor_window_pkg;
    typedef logic [11:0] coord_t;
    typedef struct packed {
        coord_t x;
        coord_t y;
    } point_t;
    typedef struct packed {
        logic [5:0] x;
        logic [5:0] y;
    } origin_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ARMED = 3'b010,
        ST_LOAD = 3'b100
    } commit_state_t;
endpackage : cursor_window_pkg

// file: hdl/cursor_window_position_regs.sv
// Purpose: APB register bank holding cursor, sprite origin and window coordinates
// Assumes: vblank comes from the display timing logic on pclk; APB answers with zero wait
// Notes: a group's staged values reach the working copy at the start of the vertical blank after its Y high byte, or both origin bytes, is written
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "cursor_window_consts.svh"

module cursor_window_position_regs (
    input wire logic pclk,                                 // APB clock, 50 MHz
    input wire logic presetn,                              // Asynchronous reset, active low
    input wire logic psel,                                 // APB select
    input wire logic penable,                              // APB access phase
    input wire logic pwrite,                               // APB write
    input wire logic [31:0] paddr,                         // APB byte address
    input wire logic [31:0] pwdata,                        // APB write data
    output logic [31:0] prdata,                            // APB read data
    output logic pready,                                   // APB ready
    output logic pslverr,                                  // APB error on unmapped address
    input wire logic vblank,                               // Vertical blank level from display timing
    output cursor_window_pkg::point_t cross_hair,          // Working cross hair intersection
    output cursor_window_pkg::point_t sprite_corner,       // Working top-left of 64x64 sprite
    output cursor_window_pkg::origin_t sprite_origin,      // Working sprite origin
    output cursor_window_pkg::point_t win_first,           // Working window first pixel, inclusive
    output cursor_window_pkg::point_t win_last             // Working window last pixel, inclusive
);

    function automatic cursor_window_pkg::coord_t join12(input logic [7:0] hi, input logic [7:0] lo);
        join12 = {hi[3:0], lo};
    endfunction : join12

    function automatic logic [7:0] mask_hi(input logic [7:0] v);
        mask_hi = {4'h0, v[3:0]};
    endfunction : mask_hi

    // Staging bytes
    logic [7:0] cxl_q, cxh_q, cyl_q, cyh_q;
    logic [5:0] sox_q, soy_q;
    logic [7:0] bxl_q, bxh_q, byl_q, byh_q;
    logic [7:0] exl_q, exh_q, eyl_q, eyh_q;
    logic vb_q;
    logic cur_pend_q, spr_pend_q, beg_pend_q, end_pend_q;
    logic spr_x_seen_q, spr_y_seen_q;
    cursor_window_pkg::commit_state_t st_q;

    wire logic [5:0] idx = paddr[7:2];
    wire logic aligned = (paddr[1:0] == 2'b00) && (paddr[31:8] == 24'h000000);
    wire logic setup = psel && !penable;
    wire logic access = psel && penable;
    wire logic hit_cxl = aligned && (idx == `CW_IDX_CURSOR_X_LOW);
    wire logic hit_cxh = aligned && (idx == `CW_IDX_CURSOR_X_HIGH);
    wire logic hit_cyl = aligned && (idx == `CW_IDX_CURSOR_Y_LOW);
    wire logic hit_cyh = aligned && (idx == `CW_IDX_CURSOR_Y_HIGH);
    wire logic hit_sox = aligned && (idx == `CW_IDX_SPRITE_ORIGIN_X);
    wire logic hit_soy = aligned && (idx == `CW_IDX_SPRITE_ORIGIN_Y);
    wire logic hit_bxl = aligned && (idx == `CW_IDX_WIN_BEGIN_X_LOW);
    wire logic hit_bxh = aligned && (idx == `CW_IDX_WIN_BEGIN_X_HIGH);
    wire logic hit_exl = aligned && (idx == `CW_IDX_WIN_END_X_LOW);
    wire logic hit_exh = aligned && (idx == `CW_IDX_WIN_END_X_HIGH);
    wire logic hit_byl = aligned && (idx == `CW_IDX_WIN_BEGIN_Y_LOW);
    wire logic hit_byh = aligned && (idx == `CW_IDX_WIN_BEGIN_Y_HIGH);
    wire logic hit_eyl = aligned && (idx == `CW_IDX_WIN_END_Y_LOW);
    wire logic hit_eyh = aligned && (idx == `CW_IDX_WIN_END_Y_HIGH);
    wire logic hit_any = hit_cxl || hit_cxh || hit_cyl || hit_cyh || hit_sox || hit_soy ||
                         hit_bxl || hit_bxh || hit_exl || hit_exh || hit_byl || hit_byh ||
                         hit_eyl || hit_eyh;
    // Writes land at the access edge; pready is pulsed high so every access lasts one cycle
    wire logic wr = access && pready && pwrite;
    wire logic [7:0] wbyte = pwdata[7:0];
    wire logic vb_rise = vblank && !vb_q;
    wire logic commit = (st_q == cursor_window_pkg::ST_LOAD);

    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        if (hit_cxl) begin
            rd_byte = cxl_q;
        end else if (hit_cxh) begin
            rd_byte = mask_hi(cxh_q);
        end else if (hit_cyl) begin
            rd_byte = cyl_q;
        end else if (hit_cyh) begin
            rd_byte = mask_hi(cyh_q);
        end else if (hit_sox) begin
            rd_byte = {2'b00, sox_q};
        end else if (hit_soy) begin
            rd_byte = {2'b00, soy_q};
        end else if (hit_bxl) begin
            rd_byte = bxl_q;
        end else if (hit_bxh) begin
            rd_byte = mask_hi(bxh_q);
        end else if (hit_exl) begin
            rd_byte = exl_q;
        end else if (hit_exh) begin
            rd_byte = mask_hi(exh_q);
        end else if (hit_byl) begin
            rd_byte = byl_q;
        end else if (hit_byh) begin
            rd_byte = mask_hi(byh_q);
        end else if (hit_eyl) begin
            rd_byte = eyl_q;
        end else if (hit_eyh) begin
            rd_byte = mask_hi(eyh_q);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= setup;
            pslverr <= setup && !hit_any;
            prdata <= (setup && !pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
        end
    end

    // Cursor position staging, cleared at reset; sprite origin staging resets to 0x1f
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cxl_q <= `CW_CURSOR_RESET;
            cxh_q <= `CW_CURSOR_RESET;
            cyl_q <= `CW_CURSOR_RESET;
            cyh_q <= `CW_CURSOR_RESET;
            sox_q <= `CW_SPRITE_RESET;
            soy_q <= `CW_SPRITE_RESET;
        end else begin
            if (wr && hit_cxl) cxl_q <= wbyte;
            if (wr && hit_cxh) cxh_q <= mask_hi(wbyte);
            if (wr && hit_cyl) cyl_q <= wbyte;
            if (wr && hit_cyh) cyh_q <= mask_hi(wbyte);
            if (wr && hit_sox) sox_q <= wbyte[5:0];
            if (wr && hit_soy) soy_q <= wbyte[5:0];
        end
    end

    // Window staging has no reset value; it is cleared only so simulation starts defined
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bxl_q <= `CW_WIN_RESET;
            bxh_q <= `CW_WIN_RESET;
            byl_q <= `CW_WIN_RESET;
            byh_q <= `CW_WIN_RESET;
            exl_q <= `CW_WIN_RESET;
            exh_q <= `CW_WIN_RESET;
            eyl_q <= `CW_WIN_RESET;
            eyh_q <= `CW_WIN_RESET;
        end else begin
            if (wr && hit_bxl) bxl_q <= wbyte;
            if (wr && hit_bxh) bxh_q <= mask_hi(wbyte);
            if (wr && hit_byl) byl_q <= wbyte;
            if (wr && hit_byh) byh_q <= mask_hi(wbyte);
            if (wr && hit_exl) exl_q <= wbyte;
            if (wr && hit_exh) exh_q <= mask_hi(wbyte);
            if (wr && hit_eyl) eyl_q <= wbyte;
            if (wr && hit_eyh) eyh_q <= mask_hi(wbyte);
        end
    end

    // Sprite origin is armed only once both X and Y have been written
    wire logic spr_both = (spr_x_seen_q || (wr && hit_sox)) && (spr_y_seen_q || (wr && hit_soy));

    // Pending flags: a trigger write in the commit cycle re-arms, so the set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_pend_q <= 1'b0;
            spr_pend_q <= 1'b0;
            beg_pend_q <= 1'b0;
            end_pend_q <= 1'b0;
            spr_x_seen_q <= 1'b0;
            spr_y_seen_q <= 1'b0;
        end else begin
            cur_pend_q <= (wr && hit_cyh) || (cur_pend_q && !commit);
            beg_pend_q <= (wr && hit_byh) || (beg_pend_q && !commit);
            end_pend_q <= (wr && hit_eyh) || (end_pend_q && !commit);
            spr_pend_q <= spr_both || (spr_pend_q && !commit);
            spr_x_seen_q <= spr_both ? 1'b0 : (spr_x_seen_q || (wr && hit_sox));
            spr_y_seen_q <= spr_both ? 1'b0 : (spr_y_seen_q || (wr && hit_soy));
        end
    end

    wire logic any_pend = cur_pend_q || spr_pend_q || beg_pend_q || end_pend_q;

    // Commit sequencer: wait for a pending group, then load on the vblank rising edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= cursor_window_pkg::ST_IDLE;
            vb_q <= 1'b0;
        end else begin
            vb_q <= vblank;
            case (st_q)
                cursor_window_pkg::ST_IDLE: if (any_pend) st_q <= cursor_window_pkg::ST_ARMED;
                cursor_window_pkg::ST_ARMED: if (vb_rise) st_q <= cursor_window_pkg::ST_LOAD;
                cursor_window_pkg::ST_LOAD: st_q <= cursor_window_pkg::ST_IDLE;
                default: st_q <= cursor_window_pkg::ST_IDLE;
            endcase
        end
    end

    wire cursor_window_pkg::point_t cur_stage = '{x: join12(cxh_q, cxl_q), y: join12(cyh_q, cyl_q)};
    wire cursor_window_pkg::point_t beg_stage = '{x: join12(bxh_q, bxl_q), y: join12(byh_q, byl_q)};
    wire cursor_window_pkg::point_t end_stage = '{x: join12(exh_q, exl_q), y: join12(eyh_q, eyl_q)};
    // Sprite corner wraps modulo 4096; the display logic clips off-screen parts
    wire cursor_window_pkg::point_t corner_d = '{x: cross_hair.x - {6'h00, sprite_origin.x},
                                                 y: cross_hair.y - {6'h00, sprite_origin.y}};

    // Working copies change only in the commit cycle, except sprite_corner, which follows cross_hair and origin every cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cross_hair <= '0;
            sprite_origin <= '{x: `CW_SPRITE_RESET, y: `CW_SPRITE_RESET};
            win_first <= '0;
            win_last <= '0;
            sprite_corner <= '0;
        end else begin
            if (commit && cur_pend_q) cross_hair <= cur_stage;
            if (commit && spr_pend_q) sprite_origin <= '{x: sox_q, y: soy_q};
            if (commit && beg_pend_q) win_first <= beg_stage;
            if (commit && end_pend_q) win_last <= end_stage;
            sprite_corner <= corner_d;
        end
    end

    property p_cursor_hold;
        @(posedge pclk) disable iff (!presetn) !commit |=> $stable(cross_hair);
    endproperty
    a_cursor_hold: assert property (p_cursor_hold) else $error("cursor moved outside commit");

    sequence s_cyh_write;
        wr && hit_cyh;
    endsequence
    sequence s_vb_edge;
        vblank && !vb_q && st_q == cursor_window_pkg::ST_ARMED;
    endsequence
    sequence s_load_cycle;
        commit;
    endsequence
    // The cursor group takes the staged value present in the load cycle itself
    property p_cursor_commit;
        @(posedge pclk) disable iff (!presetn)
            s_vb_edge ##0 cur_pend_q |=> s_load_cycle ##1 (cross_hair == $past(cur_stage));
    endproperty
    a_cursor_commit: assert property (p_cursor_commit) else $error("cursor not loaded at vblank");

    // A trigger write leaves its group pending even when it lands in the load cycle
    property p_cursor_arm;
        @(posedge pclk) disable iff (!presetn)
            s_cyh_write |=> cur_pend_q;
    endproperty
    a_cursor_arm: assert property (p_cursor_arm) else $error("cursor trigger not armed");

    property p_cur_hi_read;
        @(posedge pclk) disable iff (!presetn) setup && !pwrite && (hit_cxh || hit_cyh) |=> prdata[31:4] == 28'h0;
    endproperty
    a_cur_hi_read: assert property (p_cur_hi_read) else $error("cursor high byte upper bits set");

    property p_spr_read;
        @(posedge pclk) disable iff (!presetn) setup && !pwrite && (hit_sox || hit_soy) |=> prdata[7:6] == 2'b00;
    endproperty
    a_spr_read: assert property (p_spr_read) else $error("sprite origin bits 7..6 set");

    property p_spr_hold;
        @(posedge pclk) disable iff (!presetn) !(commit && spr_pend_q) |=> $stable(sprite_origin);
    endproperty
    a_spr_hold: assert property (p_spr_hold) else $error("sprite origin changed early");

    property p_beg_hold;
        @(posedge pclk) disable iff (!presetn) !(commit && beg_pend_q) |=> $stable(win_first);
    endproperty
    a_beg_hold: assert property (p_beg_hold) else $error("window start changed early");

    property p_end_load;
        @(posedge pclk) disable iff (!presetn) commit && end_pend_q |=> win_last == $past(end_stage);
    endproperty
    a_end_load: assert property (p_end_load) else $error("window stop not loaded");

    property p_win_hi_read;
        @(posedge pclk) disable iff (!presetn)
            setup && !pwrite && (hit_bxh || hit_byh || hit_exh || hit_eyh) |=> prdata[7:4] == 4'h0;
    endproperty
    a_win_hi_read: assert property (p_win_hi_read) else $error("window high byte upper bits set");

    // The release edge itself still runs the reset branch, so start checking one edge later
    property p_corner;
        @(posedge pclk) disable iff (!presetn)
            presetn |=> sprite_corner.x == 12'($past(cross_hair.x) - {6'h00, $past(sprite_origin.x)});
    endproperty
    a_corner: assert property (p_corner) else $error("sprite corner offset wrong");

    property p_arm_hold;
        @(posedge pclk) disable iff (!presetn)
            st_q == cursor_window_pkg::ST_ARMED && !vb_rise |=> st_q == cursor_window_pkg::ST_ARMED;
    endproperty
    a_arm_hold: assert property (p_arm_hold) else $error("armed state left without retrace");

    // One load per retrace; a second pulse would copy half-written staging bytes
    property p_load_once;
        @(posedge pclk) disable iff (!presetn) s_load_cycle |=> !commit;
    endproperty
    a_load_once: assert property (p_load_once) else $error("load cycle repeated");

    property p_cur_hi_store;
        @(posedge pclk) disable iff (!presetn)
            wr && (hit_cxh || hit_cyh) |=> cxh_q[7:4] == 4'h0 && cyh_q[7:4] == 4'h0;
    endproperty
    a_cur_hi_store: assert property (p_cur_hi_store) else $error("cursor high byte stored upper bits");

    property p_spr_load;
        @(posedge pclk) disable iff (!presetn)
            commit && spr_pend_q |=> sprite_origin.x == $past(sox_q) && sprite_origin.y == $past(soy_q);
    endproperty
    a_spr_load: assert property (p_spr_load) else $error("sprite origin not loaded");

    // A lone X write must not arm the group, or the old Y would be applied with it
    property p_spr_single;
        @(posedge pclk) disable iff (!presetn)
            wr && hit_sox && !spr_y_seen_q && !spr_pend_q |=> !spr_pend_q;
    endproperty
    a_spr_single: assert property (p_spr_single) else $error("sprite origin armed by one write");

    sequence s_sox_write;
        wr && hit_sox;
    endsequence
    property p_spr_pair;
        @(posedge pclk) disable iff (!presetn)
            s_sox_write ##0 spr_y_seen_q |=> spr_pend_q && !spr_x_seen_q && !spr_y_seen_q;
    endproperty
    a_spr_pair: assert property (p_spr_pair) else $error("sprite origin pair not armed");

    property p_beg_load;
        @(posedge pclk) disable iff (!presetn) commit && beg_pend_q |=> win_first == $past(beg_stage);
    endproperty
    a_beg_load: assert property (p_beg_load) else $error("window start not loaded");

    property p_end_hold;
        @(posedge pclk) disable iff (!presetn) !(commit && end_pend_q) |=> $stable(win_last);
    endproperty
    a_end_hold: assert property (p_end_hold) else $error("window stop changed early");

    // Unmapped accesses still complete so a stray address cannot stall the host
    property p_err_resp;
        @(posedge pclk) disable iff (!presetn) setup && !hit_any |=> pready && pslverr && prdata == 32'h0;
    endproperty
    a_err_resp: assert property (p_err_resp) else $error("unmapped access not refused");

    property p_rd_idle;
        @(posedge pclk) disable iff (!presetn) !pready |-> prdata == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside access");

endmodule : cursor_window_position_regs

`default_nettype wire

// file: dv/vblank_source_model.sv
// Purpose: display timing stand-in that produces a vertical blank level on request
// Assumes: same clock as the register bank, so no synchroniser is needed
// Notes: each request gives one blank interval of four cycles
`timescale 1ns/1ps
`default_nettype none

module vblank_source_model (
    input wire logic pclk,    // Pixel-side clock, shared with the bank
    input wire logic presetn, // Asynchronous reset, active low
    input wire logic go,      // Start one retrace interval
    output logic vblank       // Vertical blank level
);
    logic [2:0] left_q;
    logic [2:0] left_d;

    // A retrace already running is not restarted, as real timing cannot restart mid-blank
    assign left_d = (go && left_q == 3'h0) ? 3'h4 : ((left_q != 3'h0) ? left_q - 3'h1 : 3'h0);
    assign vblank = (left_q != 3'h0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left_q <= 3'h0;
        end else begin
            left_q <= left_d;
        end
    end
endmodule : vblank_source_model

`default_nettype wire

// file: dv/cursor_window_position_regs_tb.sv
// Purpose: self-checking bench for the cursor and window register bank
// Assumes: zero-wait APB slave; commits land within eight cycles of a retrace start
// Notes: coordinates are given from the first displayed pixel at (0,0)
`timescale 1ns/1ps
`default_nettype none
`include "cursor_window_consts.svh"

module cursor_window_position_regs_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic vblank;
    logic go = 1'b0;
    cursor_window_pkg::point_t cross_hair;
    cursor_window_pkg::point_t sprite_corner;
    cursor_window_pkg::origin_t sprite_origin;
    cursor_window_pkg::point_t win_first;
    cursor_window_pkg::point_t win_last;
    int err_total = 0;
    int tests_run = 0;
    logic [31:0] rd;
    logic er;

    always #10 pclk = ~pclk;

    cursor_window_position_regs DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .vblank(vblank), .cross_hair(cross_hair), .sprite_corner(sprite_corner),
        .sprite_origin(sprite_origin), .win_first(win_first), .win_last(win_last));

    vblank_source_model timing (.pclk(pclk), .presetn(presetn), .go(go), .vblank(vblank));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up

    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;
            $display("mismatch pready expected 1 seen timeout");
            wrap_up();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        xfer(1'b1, {24'h0, idx, 2'b00}, {24'h0, d});
    endtask : wr

    task automatic rdchk(input logic [5:0] idx, input logic [7:0] exp);
        xfer(1'b0, {24'h0, idx, 2'b00}, 32'h0);
        check("register read", rd, {24'h0, exp});
        check("read error flag", {31'h0, er}, 32'h0);
    endtask : rdchk

    // Leave time for the trigger to arm before the retrace begins
    task automatic retrace();
        repeat (3) @(posedge pclk);
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        repeat (8) @(posedge pclk);
    endtask : retrace

    logic [5:0] high_tab [6] = '{`CW_IDX_CURSOR_X_HIGH, `CW_IDX_CURSOR_Y_HIGH, `CW_IDX_WIN_BEGIN_X_HIGH,
        `CW_IDX_WIN_END_X_HIGH, `CW_IDX_WIN_BEGIN_Y_HIGH, `CW_IDX_WIN_END_Y_HIGH};

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rdchk(i[5:0], (i >= 4) ? 8'h1f : 8'h00);
        end
        check("reset cross hair", 32'(cross_hair), 32'h0);
        check("reset origin", 32'(sprite_origin), 32'h7df);
        check("reset corner", 32'(sprite_corner), 32'hfe1fe1);
        $display("test reset values done");

        for (int i = 0; i < 6; i++) begin
            wr(high_tab[i], 8'hff);
            rdchk(high_tab[i], 8'h0f);
        end
        wr(`CW_IDX_SPRITE_ORIGIN_X, 8'hff);
        wr(`CW_IDX_SPRITE_ORIGIN_Y, 8'hff);
        rdchk(`CW_IDX_SPRITE_ORIGIN_X, 8'h3f);
        retrace();
        check("masked cross hair", 32'(cross_hair), 32'hf00f00);
        check("masked first", 32'(win_first), 32'hf00f00);
        check("masked last", 32'(win_last), 32'hf00f00);
        check("masked origin", 32'(sprite_origin), 32'hfff);
        $display("test upper bits done");

        wr(`CW_IDX_CURSOR_X_LOW, 8'hbc);
        wr(`CW_IDX_CURSOR_X_HIGH, 8'h0a);
        wr(`CW_IDX_CURSOR_Y_LOW, 8'h23);
        retrace();
        check("held cross hair", 32'(cross_hair), 32'hf00f00);
        wr(`CW_IDX_CURSOR_Y_HIGH, 8'h01);
        check("before retrace", 32'(cross_hair), 32'hf00f00);
        retrace();
        check("new cross hair", 32'(cross_hair), 32'habc123);
        rdchk(`CW_IDX_CURSOR_Y_LOW, 8'h23);
        rdchk(`CW_IDX_CURSOR_Y_HIGH, 8'h01);
        $display("test cursor commit done");

        wr(`CW_IDX_SPRITE_ORIGIN_X, 8'h05);
        retrace();
        check("origin half", 32'(sprite_origin), 32'hfff);
        wr(`CW_IDX_SPRITE_ORIGIN_Y, 8'h3f);
        retrace();
        check("origin new", 32'(sprite_origin), 32'h17f);
        check("sprite corner", 32'(sprite_corner), 32'hab70e4);
        rdchk(`CW_IDX_SPRITE_ORIGIN_Y, 8'h3f);
        wr(`CW_IDX_SPRITE_ORIGIN_Y, 8'h01);
        wr(`CW_IDX_SPRITE_ORIGIN_X, 8'h02);
        retrace();
        check("origin swapped order", 32'(sprite_origin), 32'h081);
        check("corner swapped order", 32'(sprite_corner), 32'haba122);
        $display("test sprite origin done");

        wr(`CW_IDX_WIN_BEGIN_X_LOW, 8'hff);
        wr(`CW_IDX_WIN_BEGIN_X_HIGH, 8'h07);
        wr(`CW_IDX_WIN_BEGIN_Y_LOW, 8'h00);
        wr(`CW_IDX_WIN_END_X_LOW, 8'hff);
        wr(`CW_IDX_WIN_END_X_HIGH, 8'h0f);
        wr(`CW_IDX_WIN_BEGIN_Y_HIGH, 8'h00);
        retrace();
        check("first corner", 32'(win_first), 32'h7ff000);
        check("last held", 32'(win_last), 32'hf00f00);
        wr(`CW_IDX_WIN_END_Y_LOW, 8'h57);
        wr(`CW_IDX_WIN_END_Y_HIGH, 8'h02);
        retrace();
        check("last corner", 32'(win_last), 32'hfff257);
        rdchk(`CW_IDX_WIN_BEGIN_X_LOW, 8'hff);
        rdchk(`CW_IDX_WIN_END_Y_LOW, 8'h57);
        $display("test window commit done");

        xfer(1'b0, 32'h18, 32'h0);
        check("unmapped read", rd, 32'h0);
        check("unmapped error", {31'h0, er}, 32'h1);
        xfer(1'b1, 32'h1, 32'h55);
        check("misaligned error", {31'h0, er}, 32'h1);
        rdchk(`CW_IDX_CURSOR_X_LOW, 8'hbc);
        xfer(1'b0, 32'h60, 32'h0);
        check("beyond map error", {31'h0, er}, 32'h1);
        $display("test bus errors done");
        wrap_up();
    end
endmodule : cursor_window_position_regs_tb

`default_nettype wire
